// File: alarm_shutdown_ctrl.sv
/*
 * alarm_shutdown_ctrl: alarm flags, masks, live status, interrupt pin,
 * link switch controls and automatic switch shutdown on interrupt.
 * Assumes a serial interface decoder in the same clock domain that issues
 * one-cycle read and write strobes with an 8-bit address, and analog fault
 * detectors whose levels arrive asynchronously.
 * Assumes the six switches whose enables live elsewhere clear on a one-cycle
 * off pulse from here, and that the host releases the interrupt by reading
 * the alarm register.
 */
`timescale 1ns/1ps

module alarm_shutdown_ctrl
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // register port from the serial interface decoder
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_wr_en,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_rd_en,
    output logic      [DATA_W-1:0] reg_rdata,
    output logic                   reg_rd_valid,
    // analog fault detectors
    input  wire logic              recovery_comparator,
    input  wire logic              overtemp_detector,
    output logic                   recovery_comparator_enable,
    // interrupt pin, active low
    output logic                   int_pin_n,
    // switches owned here
    output logic                   chosen_rail_from_converter_switch_on,
    output logic                   regulator_converter_link_switch_on,
    // off pulses to switches whose enables live elsewhere
    output logic [EXT_SW_N-1:0]    ext_switch_auto_off_pulse
);

    // register fields
    logic              undervoltage_event_mask_r;
    logic              overtemp_event_mask_r;
    logic              chosen_rail_sw_r;
    logic              link_sw_r;
    logic [DATA_W-1:0] shutdown_r;
    logic [DATA_W-1:0] rdata_r;
    logic              rd_valid_r;
    logic              int_active_r;
    logic [EXT_SW_N-1:0] ext_off_r;

    // next values
    logic              undervoltage_event_mask_nxt;
    logic              overtemp_event_mask_nxt;
    logic              chosen_rail_sw_nxt;
    logic              link_sw_nxt;
    logic [DATA_W-1:0] shutdown_nxt;
    logic [DATA_W-1:0] rdata_nxt;
    logic [EXT_SW_N-1:0] ext_off_nxt;

    // decoded strobes
    logic sel_alarm;
    logic sel_shutdown;
    logic wr_alarm;
    logic wr_shutdown;
    logic rd_alarm;

    // fault path
    logic undervoltage_live_state;
    logic overtemp_live_state;
    logic undervoltage_event_flag;
    logic overtemp_event_flag;
    logic comp_gate;

    // interrupt path
    logic int_req;
    logic int_rise;
    logic link_force_off;

    // read view of the alarm register; the shutdown register reads as stored
    logic [DATA_W-1:0] alarm_view;

    // named shutdown fields
    logic link_switch_auto_off;
    logic recovery_comparator_disable;
    logic input_switch_auto_off;
    logic converter_switch2_auto_off;
    logic regulator_switch2_auto_off;
    logic regulator_switch1_auto_off;
    logic auxiliary_switch_auto_off;
    logic converter_switch1_auto_off;
    logic [EXT_SW_N-1:0] ext_auto_off;

    // address decode; only the two register offsets answer, all others read zero
    assign sel_alarm    = (reg_addr == ADDR_ALARM_LINK);
    assign sel_shutdown = (reg_addr == ADDR_SHUTDOWN);
    assign wr_alarm     = reg_wr_en & sel_alarm;
    assign wr_shutdown  = reg_wr_en & sel_shutdown;
    assign rd_alarm     = reg_rd_en & sel_alarm;

    // shutdown register fields
    assign link_switch_auto_off        = shutdown_r[LINK_OFF_BIT];
    assign recovery_comparator_disable = shutdown_r[COMP_DIS_BIT];
    assign input_switch_auto_off       = shutdown_r[INPUT_OFF_BIT];
    assign converter_switch2_auto_off  = shutdown_r[CONV2_OFF_BIT];
    assign regulator_switch2_auto_off  = shutdown_r[REG2_OFF_BIT];
    assign regulator_switch1_auto_off  = shutdown_r[REG1_OFF_BIT];
    assign auxiliary_switch_auto_off   = shutdown_r[AUX_OFF_BIT];
    assign converter_switch1_auto_off  = shutdown_r[CONV1_OFF_BIT];
    // pulse order, high to low: input, conv2, reg2, reg1, aux, conv1
    assign ext_auto_off = {input_switch_auto_off,
                           converter_switch2_auto_off,
                           regulator_switch2_auto_off,
                           regulator_switch1_auto_off,
                           auxiliary_switch_auto_off,
                           converter_switch1_auto_off};

    // the comparator is powered down and its output ignored while disabled
    // re-enabling it while the input is low shows up as a fresh event
    assign comp_gate                  = ~recovery_comparator_disable;
    assign recovery_comparator_enable = comp_gate;

    // undervoltage event: comparator asserts on falling input
    // the gate also clears the live bit, so a disabled comparator reads quiet
    fault_event_latch u_uv_latch (
        .clk         (clk),
        .arst_n      (arst_n),
        .fault_async (recovery_comparator),
        .fault_gate  (comp_gate),
        .flag_clear  (rd_alarm),
        .live_state  (undervoltage_live_state),
        .event_pulse (),  // the sticky flag and the live state are all this block uses
        .event_flag  (undervoltage_event_flag)
    );

    // over-temperature event; the detector cannot be disabled here
    fault_event_latch u_ot_latch (
        .clk         (clk),
        .arst_n      (arst_n),
        .fault_async (overtemp_detector),
        .fault_gate  (1'b1),
        .flag_clear  (rd_alarm),
        .live_state  (overtemp_live_state),
        .event_pulse (),  // the sticky flag and the live state are all this block uses
        .event_flag  (overtemp_event_flag)
    );

    // interrupt request: any latched flag that is not masked
    // the pin follows the flags, so it releases once the host reads them
    assign int_req = (undervoltage_event_flag & ~undervoltage_event_mask_r)
                   | (overtemp_event_flag & ~overtemp_event_mask_r);
    // shutdown acts on the assertion edge only, so a later rewrite sticks;
    // a level-based force would hold the switches off while the flag stands
    assign int_rise = int_req & ~int_active_r;
    assign link_force_off = int_rise & link_switch_auto_off;

    // mask writes; a mask gates the pin and the auto shutdown, the flags still latch and read
    assign undervoltage_event_mask_nxt = wr_alarm ? reg_wdata[UV_MASK_BIT]
                                                  : undervoltage_event_mask_r;
    assign overtemp_event_mask_nxt     = wr_alarm ? reg_wdata[OT_MASK_BIT]
                                                  : overtemp_event_mask_r;

    // rail switch write; no interrupt control reaches this switch
    assign chosen_rail_sw_nxt          = wr_alarm ? reg_wdata[RAIL_SW_BIT]
                                                  : chosen_rail_sw_r;

    // link switch: forced off at interrupt; shutdown wins over a same-cycle write
    // so a host write racing the alarm cannot leave the link closed
    assign link_sw_nxt = link_force_off ? 1'b0
                       : wr_alarm       ? reg_wdata[LINK_SW_BIT]
                       : link_sw_r;

    // shutdown register is fully writable
    assign shutdown_nxt = wr_shutdown ? reg_wdata : shutdown_r;

    // external switches get one off pulse; their own enables hold them off
    // a pulse, not a level, so the host may reclose them while the flag stands
    assign ext_off_nxt = int_rise ? ext_auto_off : '0;

    // read view of the alarm register
    // live bits trail the pin level by the synchroniser and the live flop
    assign alarm_view = {undervoltage_event_flag,
                         overtemp_event_flag,
                         undervoltage_event_mask_r,
                         overtemp_event_mask_r,
                         undervoltage_live_state,
                         overtemp_live_state,
                         chosen_rail_sw_r,
                         link_sw_r};

    // read mux; unmapped addresses answer zero
    // read data holds between reads so a slow host may sample it late
    assign rdata_nxt = !reg_rd_en   ? rdata_r
                     : sel_alarm    ? alarm_view
                     : sel_shutdown ? shutdown_r
                     : UNMAPPED_VAL;

    // undervoltage mask
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            undervoltage_event_mask_r <= UV_MASK_RST;
        end else begin
            undervoltage_event_mask_r <= undervoltage_event_mask_nxt;
        end
    end

    // over-temperature mask
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            overtemp_event_mask_r <= OT_MASK_RST;
        end else begin
            overtemp_event_mask_r <= overtemp_event_mask_nxt;
        end
    end

    // chosen-rail switch enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chosen_rail_sw_r <= RAIL_SW_RST;
        end else begin
            chosen_rail_sw_r <= chosen_rail_sw_nxt;
        end
    end

    // link switch enable
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            link_sw_r <= LINK_SW_RST;
        end else begin
            link_sw_r <= link_sw_nxt;
        end
    end

    // shutdown register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown_r <= SHUTDOWN_RST;
        end else begin
            shutdown_r <= shutdown_nxt;
        end
    end

    // interrupt state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_active_r <= 1'b0;
        end else begin
            int_active_r <= int_req;
        end
    end

    // off pulses, one cycle long
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_off_r <= '0;
        end else begin
            ext_off_r <= ext_off_nxt;
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // read answer strobe, one cycle long
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= reg_rd_en;
        end
    end

    // outputs
    assign reg_rdata                            = rdata_r;
    assign reg_rd_valid                         = rd_valid_r;
    assign int_pin_n                            = ~int_active_r;
    assign chosen_rail_from_converter_switch_on = chosen_rail_sw_r;
    assign regulator_converter_link_switch_on   = link_sw_r;
    assign ext_switch_auto_off_pulse            = ext_off_r;

endmodule // alarm_shutdown_ctrl

// File: alarm_pkg.sv
/*
 * alarm_pkg: register offsets, field positions and reset values for the
 * alarm, interrupt and automatic switch shutdown block.
 * Assumes an 8-bit register port driven by the serial interface decoder.
 */
package alarm_pkg;

    // register port geometry
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 8;

    // register offsets
    localparam logic [7:0] ADDR_ALARM_LINK = 8'h07;
    localparam logic [7:0] ADDR_SHUTDOWN   = 8'h08;

    // alarm_and_link_switch_ctrl field positions
    localparam int unsigned UV_FLAG_BIT   = 7;
    localparam int unsigned OT_FLAG_BIT   = 6;
    localparam int unsigned UV_MASK_BIT   = 5;
    localparam int unsigned OT_MASK_BIT   = 4;
    localparam int unsigned UV_LIVE_BIT   = 3;
    localparam int unsigned OT_LIVE_BIT   = 2;
    localparam int unsigned RAIL_SW_BIT   = 1;
    localparam int unsigned LINK_SW_BIT   = 0;

    // fault_switch_shutdown_ctrl field positions
    localparam int unsigned INPUT_OFF_BIT = 7;
    localparam int unsigned CONV2_OFF_BIT = 6;
    localparam int unsigned REG2_OFF_BIT  = 5;
    localparam int unsigned REG1_OFF_BIT  = 4;
    localparam int unsigned AUX_OFF_BIT   = 3;
    localparam int unsigned CONV1_OFF_BIT = 2;
    localparam int unsigned LINK_OFF_BIT  = 1;
    localparam int unsigned COMP_DIS_BIT  = 0;

    // number of external switches that only receive an off pulse
    localparam int unsigned EXT_SW_N      = 6;

    // values after reset
    localparam logic       UV_MASK_RST    = 1'b0;
    localparam logic       OT_MASK_RST    = 1'b1;
    localparam logic       RAIL_SW_RST    = 1'b0;
    localparam logic       LINK_SW_RST    = 1'b0;
    localparam logic [7:0] SHUTDOWN_RST   = 8'hBB;
    localparam logic [7:0] RDATA_RST      = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL   = 8'h00;

    // synchroniser depth for pin-level fault inputs
    localparam int unsigned SYNC_STAGES   = 2;

endpackage

// File: fault_event_latch.sv
/*
 * fault_event_latch: brings one asynchronous fault level into the clock
 * domain, reports its live state and latches its rising edge into a sticky
 * flag that a clear strobe empties.
 * Assumes the fault level comes from an analog detector outside this clock.
 */
`timescale 1ns/1ps
module fault_event_latch
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // fault source
    input  wire logic fault_async,
    input  wire logic fault_gate,
    // flag control
    input  wire logic flag_clear,
    // results
    output logic      live_state,
    output logic      event_pulse,
    output logic      event_flag
);

    logic meta_r;
    logic sync_r;
    logic live_r;
    logic flag_r;

    logic live_nxt;
    logic rise;
    logic flag_nxt;

    // the gate drops the level while the detector is disabled
    assign live_nxt = sync_r & fault_gate;
    assign rise     = live_nxt & ~live_r;
    // set beats clear so an event in the read cycle survives
    assign flag_nxt = rise | (flag_r & ~flag_clear);

    // two-stage synchroniser; meta_r is read only by sync_r
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= fault_async;
            sync_r <= meta_r;
        end
    end

    // live state and sticky flag
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            live_r <= 1'b0;
            flag_r <= 1'b0;
        end else begin
            live_r <= live_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign live_state  = live_r;
    assign event_pulse = rise;
    assign event_flag  = flag_r;

endmodule // fault_event_latch

// File: alarm_shutdown_ctrl_assertions.sv
/* alarm_shutdown_ctrl_assertions: port-level checks of the alarm block.
   Assumes it is bound to alarm_shutdown_ctrl and sees only its ports. */
`timescale 1ns/1ps
module alarm_shutdown_ctrl_assertions
    import alarm_pkg::*;
(
    // clock and reset
    input wire logic                clk,
    input wire logic                arst_n,
    // register port
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic                reg_wr_en,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_rd_en,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                reg_rd_valid,
    // pin and switches
    input wire logic                recovery_comparator_enable,
    input wire logic                int_pin_n,
    input wire logic                chosen_rail_from_converter_switch_on,
    input wire logic                regulator_converter_link_switch_on,
    input wire logic [EXT_SW_N-1:0] ext_switch_auto_off_pulse
);
    logic [7:0] sd_r;
    logic [7:0] rd_sd_r;
    logic [7:0] rd_addr_r;
    // shadow of the shutdown register, so pulses and reads can be predicted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sd_r      <= SHUTDOWN_RST;
            rd_sd_r   <= SHUTDOWN_RST;
            rd_addr_r <= 8'h00;
        end else begin
            if (reg_wr_en && reg_addr == ADDR_SHUTDOWN) sd_r <= reg_wdata;
            if (reg_rd_en) rd_sd_r <= sd_r;
            if (reg_rd_en) rd_addr_r <= reg_addr;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    rd_latency_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read answer missing");
    comp_enable_a: assert property (reg_wr_en && reg_addr == ADDR_SHUTDOWN
        |=> recovery_comparator_enable == !$past(reg_wdata[0])) else $error("comparator enable wrong");
    shutdown_read_a: assert property (reg_rd_valid && rd_addr_r == ADDR_SHUTDOWN |-> reg_rdata == rd_sd_r)
        else $error("shutdown readback wrong");
    unmapped_read_a: assert property (reg_rd_valid && rd_addr_r != ADDR_SHUTDOWN
        && rd_addr_r != ADDR_ALARM_LINK |-> reg_rdata == UNMAPPED_VAL) else $error("unmapped read not zero");
    int_flag_a: assert property (reg_rd_valid && rd_addr_r == ADDR_ALARM_LINK &&
        ((reg_rdata[7] && !reg_rdata[5]) || (reg_rdata[6] && !reg_rdata[4])) |-> !int_pin_n)
        else $error("unmasked flag without interrupt");
    pulse_shape_a: assert property (ext_switch_auto_off_pulse ==
        ($fell(int_pin_n) ? $past(sd_r[7:2]) : 6'h00)) else $error("off pulses wrong");
    link_off_a: assert property ($fell(int_pin_n) && $past(sd_r[1])
        |-> !regulator_converter_link_switch_on) else $error("link switch not forced off");
    switch_write_a: assert property (reg_wr_en && reg_addr == ADDR_ALARM_LINK
        |=> chosen_rail_from_converter_switch_on == $past(reg_wdata[1])
        && ($fell(int_pin_n) || regulator_converter_link_switch_on == $past(reg_wdata[0])))
        else $error("switch write lost");
    link_hold_a: assert property (!regulator_converter_link_switch_on
        && !(reg_wr_en && reg_addr == ADDR_ALARM_LINK) |=> !regulator_converter_link_switch_on)
        else $error("link switch reclosed");
    cover property ($fell(int_pin_n));
    cover property (reg_rd_valid && reg_rdata[6]);
    cover property (reg_rd_valid && rd_addr_r == ADDR_SHUTDOWN);
endmodule // alarm_shutdown_ctrl_assertions

bind alarm_shutdown_ctrl alarm_shutdown_ctrl_assertions chk_u (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .recovery_comparator_enable(recovery_comparator_enable),
    .int_pin_n(int_pin_n), .chosen_rail_from_converter_switch_on(chosen_rail_from_converter_switch_on),
    .regulator_converter_link_switch_on(regulator_converter_link_switch_on),
    .ext_switch_auto_off_pulse(ext_switch_auto_off_pulse));

// File: host_model.sv
/* host_model: the serial host, seen as one-cycle register strobes.
   Assumes the block samples strobes on the rising clock edge. */
`timescale 1ns/1ps
module host_model
    import alarm_pkg::*;
(
    // clock
    input  wire logic              clk,
    // register port towards the block
    output logic      [ADDR_W-1:0] reg_addr,
    output logic                   reg_wr_en,
    output logic      [DATA_W-1:0] reg_wdata,
    output logic                   reg_rd_en
);
    // idle lines carry inverted values so a stale one never looks valid
    initial begin
        reg_addr  = 8'hFF;
        reg_wdata = 8'hFF;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end
    // one access per call; alarm flags are only ever cleared by a read of the alarm register or by reset
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic wr);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr_en = wr;
        reg_rd_en = !wr;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
endmodule // host_model

// File: alarm_shutdown_ctrl_tb.sv
/* alarm_shutdown_ctrl_tb: self-checking bench of the alarm block.
   Assumes host_model drives the register port and the checker is bound. */
`timescale 1ns/1ps
module alarm_shutdown_ctrl_tb
    import alarm_pkg::*;
;
    logic       clk;
    logic       arst_n;
    logic       uv_in;
    logic       ot_in;
    wire  [7:0] addr;
    wire  [7:0] wdata;
    wire  [7:0] rdata;
    wire        wr;
    wire        rd;
    wire        rvalid;
    wire        cmp_en;
    wire        int_n;
    wire        rail;
    wire        link;
    wire  [5:0] pulse;
    int         errors;
    int         num_checks;
    logic [7:0] exp_q[$];
    logic [7:0] w;
    logic [7:0] sd;

    alarm_shutdown_ctrl dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wr_en(wr),
        .reg_wdata(wdata), .reg_rd_en(rd), .reg_rdata(rdata), .reg_rd_valid(rvalid),
        .recovery_comparator(uv_in), .overtemp_detector(ot_in), .recovery_comparator_enable(cmp_en),
        .int_pin_n(int_n), .chosen_rail_from_converter_switch_on(rail),
        .regulator_converter_link_switch_on(link), .ext_switch_auto_off_pulse(pulse));
    host_model host_u (.clk(clk), .reg_addr(addr), .reg_wr_en(wr), .reg_wdata(wdata), .reg_rd_en(rd));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(a, 8'h00, 1'b0);
    endtask
    task automatic end_sim();
        if (exp_q.size() != 0) errors++;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // answers are matched in issue order; an unasked answer is a mismatch
    always @(negedge clk) begin
        if (rvalid === 1'b1 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
        else if (rvalid === 1'b1) chk(8'hFF, 8'h00);
    end

    // raise one fault with its mask chosen, then read the flag out twice
    task automatic fault_run(input logic uv, input logic m);
        logic mu;
        logic mo;
        int   n;
        mu = uv ? m : 1'b1;
        mo = uv ? 1'b1 : m;
        sd = ($urandom & 8'hFC) | 8'h02;
        host_u.access(ADDR_SHUTDOWN, sd, 1'b1);
        host_u.access(ADDR_ALARM_LINK, {2'b11, mu, mo, 4'hF}, 1'b1);
        @(negedge clk);
        uv_in = uv;
        ot_in = !uv;
        n = 0;
        while (int_n !== 1'b0 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk({7'h00, int_n}, {7'h00, m});
        if (!m && n == 8) end_sim();
        if (!m) chk({2'b00, pulse}, {2'b00, sd[7:2]});
        rd_exp(ADDR_ALARM_LINK, {uv, !uv, mu, mo, uv, !uv, 1'b1, m});
        rd_exp(ADDR_ALARM_LINK, {2'b00, mu, mo, uv, !uv, 1'b1, m});
        chk({7'h00, int_n}, 8'h01);
        uv_in = 1'b0;
        ot_in = 1'b0;
        repeat (4) @(negedge clk);
        $display("test fault uv=%0d masked=%0d done", uv, m);
    endtask

    initial begin
        uv_in = 1'b0;
        ot_in = 1'b0;
        arst_n = 1'b0;
        errors = 0;
        num_checks = 0;
        w = $urandom(32'hFC743355);
        repeat (4) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        // reset state, boundary addresses, comparator held off by default
        chk({6'h00, int_n, cmp_en}, 8'h02);
        uv_in = 1'b1;
        rd_exp(ADDR_ALARM_LINK, 8'h10);
        rd_exp(ADDR_SHUTDOWN, SHUTDOWN_RST);
        rd_exp(8'h06, 8'h00);
        rd_exp(8'h09, 8'h00);
        repeat (4) @(negedge clk);
        rd_exp(ADDR_ALARM_LINK, 8'h10);
        chk({7'h00, int_n}, 8'h01);
        uv_in = 1'b0;
        $display("test reset done");
        // random writes, read-only bits must not take
        w = $urandom;
        host_u.access(ADDR_ALARM_LINK, w, 1'b1);
        rd_exp(ADDR_ALARM_LINK, {2'b00, w[5:4], 2'b00, w[1:0]});
        chk({6'h00, rail, link}, {6'h00, w[1:0]});
        w = $urandom;
        host_u.access(ADDR_SHUTDOWN, w, 1'b1);
        rd_exp(ADDR_SHUTDOWN, w);
        chk({7'h00, cmp_en}, {7'h00, !w[0]});
        $display("test registers done");
        for (int k = 0; k < 4; k++) fault_run(k[1], k[0]);
        repeat (2) @(negedge clk);
        end_sim();
    end
endmodule // alarm_shutdown_ctrl_tb
